// file: scc_pkg.sv
// constants shared by the serial channel control register bank
package scc_pkg;
   // ----------------------------------------------------------------
   // address windows
   // ----------------------------------------------------------------
   localparam logic [31:0] CH0_BASE = 32'h4800_0000;
   localparam logic [31:0] CH1_BASE = 32'h4800_0200;
   localparam logic [31:0] CHAN_END = 32'h4800_03FF;
   localparam int CH_SEL_BIT = 9;
   localparam int OFS_W = 9;
   localparam int NUM_CH = 2;
   // channel-relative register offsets
   localparam logic [8:0] OFS_ID = 9'h008;
   localparam logic [8:0] OFS_FDR = 9'h010;
   localparam logic [8:0] OFS_CCR = 9'h040;
   localparam logic [8:0] OFS_IRQ_STAT = 9'h070;
   localparam logic [8:0] OFS_IRQ_CLR = 9'h074;
   localparam logic [8:0] OFS_IRQ_EN = 9'h078;
   // ----------------------------------------------------------------
   // identification fields
   // ----------------------------------------------------------------
   localparam logic [7:0] ID_REVISION = 8'h01;
   localparam logic [7:0] ID_TYPE = 8'h5A;    // arbitrary value
   localparam logic [15:0] ID_NUMBER = 16'h1234; // arbitrary value
   // ----------------------------------------------------------------
   // channel control fields
   // ----------------------------------------------------------------
   localparam int MODE_LSB = 0;
   localparam int HPC_LSB = 6;
   localparam int PM_LSB = 8;
   localparam int RECEIVER_START_IRQ_ENABLE_BIT = 10;
   localparam logic [31:0] CCR_RESET = 32'h0000_0000;
   localparam logic [31:0] CCR_WMASK = 32'h0001_FFCF;
   localparam logic [31:0] FDR_RESET = 32'h0000_0000;
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_SYNC = 4'h1;
   localparam logic [3:0] MODE_ASYNC = 4'h2;
   localparam logic [3:0] MODE_SOUND = 4'h3;
   localparam logic [3:0] MODE_BUS = 4'h4;
   // capability bits: sync, async, bus, sound
   localparam logic [3:0] PROTO_AVAIL = 4'hF;
   localparam int CAP_SYNC = 0;
   localparam int CAP_ASYNC = 1;
   localparam int CAP_BUS = 2;
   localparam int CAP_SOUND = 3;
   // parity selections
   localparam logic [1:0] PM_OFF = 2'h0;
   localparam logic [1:0] PM_RSVD = 2'h1;
   localparam logic [1:0] PM_ODD_ONE = 2'h2;
   localparam logic [1:0] PM_EVEN_ONE = 2'h3;
   localparam int PAR_DW = 16;
   // port control line masks
   localparam logic [5:0] HPC_IN_0 = 6'h00;
   localparam logic [5:0] HPC_IN_1 = 6'h01;
   localparam logic [5:0] HPC_IN_2 = 6'h09;
   localparam logic [5:0] HPC_IN_3 = 6'h39;
   localparam logic [3:0] HPC_OUT_0 = 4'h0;
   localparam logic [3:0] HPC_OUT_1 = 4'h1;
   localparam logic [3:0] HPC_OUT_2 = 4'h3;
   localparam logic [3:0] HPC_OUT_3 = 4'hF;
   // service requests and interrupt status layout
   localparam int SR_N = 6;
   localparam int PTR_W = 3;
   localparam int IRQ_W = 4;
   localparam int IRQ_RXS_LSB = 0;
   localparam int IRQ_PRIV_LSB = 2;
endpackage : scc_pkg

// file: scc_parity.sv
// registered parity generator for one channel
module scc_parity (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // data and selection
   input wire logic [scc_pkg::PAR_DW-1:0] data,
   input wire logic [1:0] sel,
   // result
   output logic par_bit,
   output logic par_en
);
   typedef struct packed {
      logic bit_v;
      logic en;
   } scc_par_s;
   scc_par_s st_reg;
   scc_par_s st_next;

   // -----------------------------------------------------------------
   // parity selection
   // -----------------------------------------------------------------
   // reserved selection behaves as disabled
   always_comb begin
      st_next = '0;
      case (sel)
         scc_pkg::PM_ODD_ONE: begin
            st_next.en = 1'b1;
            st_next.bit_v = ^data;
         end
         scc_pkg::PM_EVEN_ONE: begin
            st_next.en = 1'b1;
            st_next.bit_v = ~(^data);
         end
         default: begin
            st_next = '0;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign par_bit = st_reg.bit_v;
   assign par_en = st_reg.en;
endmodule : scc_parity

// file: scc_portctl.sv
// port control line decoder for one channel
module scc_portctl (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // selection
   input wire logic [1:0] hpc,
   // line enables
   output logic [5:0] in_en,
   output logic [3:0] out_en
);
   typedef struct packed {
      logic [5:0] inl;
      logic [3:0] outl;
   } scc_pc_s;
   scc_pc_s st_reg;
   scc_pc_s st_next;

   // -----------------------------------------------------------------
   // line set decode
   // -----------------------------------------------------------------
   always_comb begin
      st_next = '0;
      case (hpc)
         2'h1: begin
            st_next.inl = scc_pkg::HPC_IN_1;
            st_next.outl = scc_pkg::HPC_OUT_1;
         end
         2'h2: begin
            st_next.inl = scc_pkg::HPC_IN_2;
            st_next.outl = scc_pkg::HPC_OUT_2;
         end
         2'h3: begin
            st_next.inl = scc_pkg::HPC_IN_3;
            st_next.outl = scc_pkg::HPC_OUT_3;
         end
         default: begin
            st_next.inl = scc_pkg::HPC_IN_0;
            st_next.outl = scc_pkg::HPC_OUT_0;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_reg <= '0;
      end else if (ce) begin
         st_reg <= st_next;
      end
   end

   assign in_en = st_reg.inl;
   assign out_en = st_reg.outl;
endmodule : scc_portctl

// file: scc_regs.sv
// two-channel serial channel control register bank on a wishbone slave
//
// Function
// - decode channel bases plus relative offsets
// - identification revision number reads 01 hex
// - identification type and number read fixed
// - divider register writable only when privileged
// - mode field selects off or protocol
// - reserved or unavailable mode means disabled
// - port control field selects line sets
// - parity field selects odd or even
// - receiver start raises pointed service request
// - unused control bits read zero
module scc_regs (
   // clock, reset, freeze
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CE,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [31:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic PRIV_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   // channel events and routing
   input wire logic [1:0] RX_START_I,
   input wire logic [5:0] TB_NODE_PTR_I,
   input wire logic [31:0] PAR_DATA_I,
   // channel configuration outputs
   output logic [7:0] MODE_O,
   output logic [63:0] FDIV_O,
   output logic [1:0] PAR_BIT_O,
   output logic [1:0] PAR_EN_O,
   output logic [11:0] PORT_IN_EN_O,
   output logic [7:0] PORT_OUT_EN_O,
   // service requests and interrupt
   output logic [5:0] SR_O,
   output logic IRQ_O
);
   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   typedef struct packed {
      logic [1:0][31:0] channel_control;
      logic [1:0][31:0] fractional_divider_reg;
      logic [1:0][3:0] mode_eff;
      logic [3:0] irq_stat;
      logic [3:0] irq_en;
      logic [5:0] sr;
      logic [31:0] rdata;
      logic ack;
   } scc_state_s;

   scc_state_s st_reg;
   scc_state_s st_next;

   logic req;
   logic hit;
   logic ch;
   logic [8:0] ofs;
   logic [31:0] bmask;

   // -----------------------------------------------------------------
   // address decode
   // -----------------------------------------------------------------
   // a new request only while no answer is pending, so one access gives one ack
   assign req = WB_CYC_I & WB_STB_I & ~st_reg.ack;
   assign hit = (WB_ADR_I >= scc_pkg::CH0_BASE) && (WB_ADR_I <= scc_pkg::CHAN_END);
   assign ch = (WB_ADR_I >= scc_pkg::CH1_BASE);
   assign ofs = WB_ADR_I[scc_pkg::OFS_W-1:0];
   assign bmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

   // -----------------------------------------------------------------
   // effective mode
   // -----------------------------------------------------------------
   // a code naming a protocol that is absent falls back to disabled
   function automatic logic [3:0] scc_eff_mode(input logic [3:0] m);
      logic [3:0] r;
      r = scc_pkg::MODE_OFF;
      case (m)
         scc_pkg::MODE_SYNC: begin
            if (scc_pkg::PROTO_AVAIL[scc_pkg::CAP_SYNC]) r = m;
         end
         scc_pkg::MODE_ASYNC: begin
            if (scc_pkg::PROTO_AVAIL[scc_pkg::CAP_ASYNC]) r = m;
         end
         scc_pkg::MODE_SOUND: begin
            if (scc_pkg::PROTO_AVAIL[scc_pkg::CAP_SOUND]) r = m;
         end
         scc_pkg::MODE_BUS: begin
            if (scc_pkg::PROTO_AVAIL[scc_pkg::CAP_BUS]) r = m;
         end
         default: begin
            r = scc_pkg::MODE_OFF;
         end
      endcase
      return r;
   endfunction : scc_eff_mode

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   function automatic logic [31:0] scc_read(input scc_state_s s, input logic c,
                                             input logic [8:0] o);
      logic [31:0] r;
      r = '0;
      case (o)
         scc_pkg::OFS_ID: begin
            r = {scc_pkg::ID_NUMBER, scc_pkg::ID_TYPE, scc_pkg::ID_REVISION};
         end
         scc_pkg::OFS_FDR: begin
            r = s.fractional_divider_reg[c];
         end
         scc_pkg::OFS_CCR: begin
            r = s.channel_control[c] & scc_pkg::CCR_WMASK;
         end
         scc_pkg::OFS_IRQ_STAT: begin
            r = {28'h000_0000, s.irq_stat};
         end
         scc_pkg::OFS_IRQ_EN: begin
            r = {28'h000_0000, s.irq_en};
         end
         default: begin
            r = '0; // unmapped and write-only locations read zero
         end
      endcase
      return r;
   endfunction : scc_read

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      logic [3:0] evt;
      logic [2:0] ptr;
      evt = '0;
      ptr = '0;
      st_next = st_reg;
      st_next.ack = 1'b0;
      st_next.sr = '0;

      // bus access: answered one cycle after the request is seen
      if (req) begin
         st_next.ack = 1'b1;
         st_next.rdata = '0;
         if (!WB_WE_I) begin
            if (hit) begin
               st_next.rdata = scc_read(st_reg, ch, ofs);
            end
         end else if (hit) begin
            case (ofs)
               scc_pkg::OFS_FDR: begin
                  if (PRIV_I) begin
                     st_next.fractional_divider_reg[ch] = (st_reg.fractional_divider_reg[ch] & ~bmask) | (WB_DAT_I & bmask);
                  end else begin
                     evt[scc_pkg::IRQ_PRIV_LSB + int'(ch)] = 1'b1;
                  end
               end
               scc_pkg::OFS_CCR: begin
                  // control is privileged too, like the divider
                  if (PRIV_I) begin
                     st_next.channel_control[ch] = ((st_reg.channel_control[ch] & ~bmask) | (WB_DAT_I & bmask))
                                       & scc_pkg::CCR_WMASK;
                  end else begin
                     evt[scc_pkg::IRQ_PRIV_LSB + int'(ch)] = 1'b1;
                  end
               end
               scc_pkg::OFS_IRQ_CLR: begin
                  if (WB_SEL_I[0]) begin
                     st_next.irq_stat = st_reg.irq_stat & ~WB_DAT_I[scc_pkg::IRQ_W-1:0];
                  end
               end
               scc_pkg::OFS_IRQ_EN: begin
                  if (WB_SEL_I[0]) begin
                     st_next.irq_en = WB_DAT_I[scc_pkg::IRQ_W-1:0];
                  end
               end
               default: begin
                  st_next.irq_en = st_reg.irq_en; // identification and holes ignore writes
               end
            endcase
         end
      end

      // per channel receiver start routing and mode resolution
      for (int i = 0; i < scc_pkg::NUM_CH; i++) begin
         ptr = TB_NODE_PTR_I[i*scc_pkg::PTR_W +: scc_pkg::PTR_W];
         if (RX_START_I[i]) begin
            evt[scc_pkg::IRQ_RXS_LSB + i] = 1'b1;
            if (st_reg.channel_control[i][scc_pkg::RECEIVER_START_IRQ_ENABLE_BIT] && (int'(ptr) < scc_pkg::SR_N)) begin
               st_next.sr[ptr] = 1'b1;
            end
         end
         st_next.mode_eff[i] = scc_eff_mode(st_next.channel_control[i][scc_pkg::MODE_LSB +: 4]);
      end

      // sticky status: a new event wins over a clear in the same cycle
      st_next.irq_stat = st_next.irq_stat | evt;
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         st_reg.channel_control <= {scc_pkg::CCR_RESET, scc_pkg::CCR_RESET};
         st_reg.fractional_divider_reg <= {scc_pkg::FDR_RESET, scc_pkg::FDR_RESET};
         st_reg.mode_eff <= '0;
         st_reg.irq_stat <= '0;
         st_reg.irq_en <= '0;
         st_reg.sr <= '0;
         st_reg.rdata <= '0;
         st_reg.ack <= 1'b0;
      end else if (CE) begin
         st_reg <= st_next;
      end
   end

   // -----------------------------------------------------------------
   // per channel helpers
   // -----------------------------------------------------------------
   // port control is decoded even when the mode makes it useless;
   // software is expected to keep it zero there
   for (genvar g = 0; g < scc_pkg::NUM_CH; g++) begin : g_ch
      scc_parity u_par (
         .clk(REF_CLK),
         .rst(RST),
         .ce(CE),
         .data(PAR_DATA_I[g*scc_pkg::PAR_DW +: scc_pkg::PAR_DW]),
         .sel(st_reg.channel_control[g][scc_pkg::PM_LSB +: 2]),
         .par_bit(PAR_BIT_O[g]),
         .par_en(PAR_EN_O[g])
      );
      scc_portctl u_pc (
         .clk(REF_CLK),
         .rst(RST),
         .ce(CE),
         .hpc(st_reg.channel_control[g][scc_pkg::HPC_LSB +: 2]),
         .in_en(PORT_IN_EN_O[g*6 +: 6]),
         .out_en(PORT_OUT_EN_O[g*4 +: 4])
      );
      assign MODE_O[g*4 +: 4] = st_reg.mode_eff[g];
      assign FDIV_O[g*32 +: 32] = st_reg.fractional_divider_reg[g];
   end

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign WB_DAT_O = st_reg.rdata;
   assign WB_ACK_O = st_reg.ack;
   assign SR_O = st_reg.sr;
   assign IRQ_O = |(st_reg.irq_stat & st_reg.irq_en); // level, high while enabled bit set
endmodule : scc_regs

// file: scc_regs_monitor.sv
// assertion checker for the serial channel control register bank
module scc_regs_monitor (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic CE,
   // wishbone slave
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [31:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic PRIV_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   // events and configuration outputs
   input wire logic [1:0] RX_START_I,
   input wire logic [7:0] MODE_O,
   input wire logic [63:0] FDIV_O,
   input wire logic [1:0] PAR_EN_O,
   input wire logic [11:0] PORT_IN_EN_O,
   input wire logic [7:0] PORT_OUT_EN_O,
   input wire logic [5:0] SR_O,
   input wire logic IRQ_O
);
   // ----------------------------------------------------------------
   // access decode helpers
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   localparam logic [31:0] A_CTL0 = scc_pkg::CH0_BASE + {23'h0, scc_pkg::OFS_CCR};
   localparam logic [31:0] A_DIV0 = scc_pkg::CH0_BASE + {23'h0, scc_pkg::OFS_FDR};
   localparam logic [31:0] A_ID0 = scc_pkg::CH0_BASE + {23'h0, scc_pkg::OFS_ID};
   // the request is still held in the ack cycle, so address qualifies the answer
   wire logic wr_ctl0 = WB_ACK_O && WB_WE_I && PRIV_I && WB_SEL_I[0] && WB_ADR_I == A_CTL0;
   wire logic rd_ctl0 = WB_ACK_O && !WB_WE_I && WB_ADR_I == A_CTL0;
   function automatic logic [5:0] in_mask(input logic [1:0] h);
      return {h == 2'h3, h == 2'h3, h[1], 1'h0, 1'h0, h != 2'h0};
   endfunction : in_mask
   function automatic logic [3:0] out_mask(input logic [1:0] h);
      return {h == 2'h3, h == 2'h3, h[1], h != 2'h0};
   endfunction : out_mask
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   chk_ack_one_cycle: assert property ((WB_ACK_O && CE) |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");
   chk_ack_answer: assert property ((CE && WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
      else $error("request not acked in one cycle");
   chk_id_value: assert property ((WB_ACK_O && !WB_WE_I && WB_ADR_I == A_ID0) |->
      WB_DAT_O == {scc_pkg::ID_NUMBER, scc_pkg::ID_TYPE, 8'h01}) else $error("bad id read");
   chk_unused_zero: assert property (rd_ctl0 |-> WB_DAT_O[5:4] == 2'h0 &&
      WB_DAT_O[31:17] == 15'h0) else $error("unused control bits not zero");
   chk_mode_decode: assert property (wr_ctl0 |-> MODE_O[3:0] ==
      ((WB_DAT_I[3:0] > 4'h4) ? 4'h0 : WB_DAT_I[3:0])) else $error("bad effective mode");
   chk_priv_block: assert property ((WB_ACK_O && WB_WE_I && !PRIV_I && WB_ADR_I == A_DIV0)
      |-> $stable(FDIV_O[31:0])) else $error("unprivileged divider write took effect");
   chk_port_lines: assert property (wr_ctl0 |=> PORT_IN_EN_O[5:0] ==
      in_mask($past(WB_DAT_I[7:6])) && PORT_OUT_EN_O[3:0] == out_mask($past(WB_DAT_I[7:6])))
      else $error("bad port line masks");
   chk_parity_en: assert property (wr_ctl0 |=> PAR_EN_O[0] == $past(WB_DAT_I[9]))
      else $error("bad parity enable");
   chk_sr_cause: assert property ((SR_O != 6'h0) |-> $past(RX_START_I) != 2'h0)
      else $error("service request without receiver start");
   // main scenarios
   cov_ctl_write: cover property (wr_ctl0);
   cov_sr_pulse: cover property (SR_O != 6'h0);
   cov_irq: cover property (IRQ_O);
endmodule : scc_regs_monitor

bind scc_regs scc_regs_monitor i_mon (.*);

// file: scc_regs_test.sv
// self-checking bench for the serial channel control register bank
module scc_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // signals and tasks
   // ----------------------------------------------------------------
   logic REF_CLK = 1'h0, RST = 1'h1, CE = 1'h1;
   logic WB_CYC_I = 1'h0, WB_STB_I = 1'h0, WB_WE_I = 1'h0, PRIV_I = 1'h0;
   logic [31:0] WB_ADR_I = 32'h0, WB_DAT_I = 32'h0, PAR_DATA_I = 32'h0;
   logic [3:0] WB_SEL_I = 4'h0;
   logic [1:0] RX_START_I = 2'h0;
   logic [5:0] TB_NODE_PTR_I = 6'h0;
   logic [31:0] WB_DAT_O, rd;
   logic WB_ACK_O, IRQ_O;
   logic [7:0] MODE_O, PORT_OUT_EN_O;
   logic [63:0] FDIV_O;
   logic [1:0] PAR_BIT_O, PAR_EN_O;
   logic [11:0] PORT_IN_EN_O;
   logic [5:0] SR_O;
   logic [5:0] hin [4] = '{6'h00, 6'h01, 6'h09, 6'h39};
   logic [3:0] hout [4] = '{4'h0, 4'h1, 4'h3, 4'hF};
   int err_count = 0, samples_checked = 0, cycles = 0;
   scc_regs i_dut (.*);
   // 20 MHz reference clock
   initial begin
      forever #25 REF_CLK = ~REF_CLK;
   end
   task automatic print_verdict;
      if (err_count == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   // classic cycle; nothing moves until ack is sampled, so slow answers are safe
   task automatic bus(input logic we, input logic ch, input logic [8:0] ofs,
                      input logic [31:0] d, input logic pv);
      @(posedge REF_CLK);
      WB_CYC_I <= 1'h1;
      WB_STB_I <= 1'h1;
      WB_WE_I <= we;
      WB_SEL_I <= 4'hF;
      WB_DAT_I <= d;
      PRIV_I <= pv;
      WB_ADR_I <= (ch ? scc_pkg::CH1_BASE : scc_pkg::CH0_BASE) + {23'h0, ofs};
      do @(posedge REF_CLK); while (WB_ACK_O !== 1'h1);
      rd = WB_DAT_O;
      WB_CYC_I <= 1'h0;
      WB_STB_I <= 1'h0;
      #1;
   endtask : bus
   // one-cycle receiver start, service request looked at in its only cycle
   task automatic pulse(input logic [1:0] ev, input logic [5:0] exp);
      @(posedge REF_CLK);
      RX_START_I <= ev;
      @(posedge REF_CLK);
      RX_START_I <= 2'h0;
      #1;
      check(SR_O, exp, "service request");
   endtask : pulse
   // hang guard, far above the few hundred cycles the sequence needs
   always @(posedge REF_CLK) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         print_verdict();
      end
   end
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (10) @(posedge REF_CLK);
      RST <= 1'h0;
      for (int c = 0; c < 2; c++) begin
         bus(0, c[0], scc_pkg::OFS_CCR, 32'h0, 1);
         check(rd, 32'h0000_0000, "control reset");
         bus(0, c[0], scc_pkg::OFS_ID, 32'h0, 0);
         check(rd, {scc_pkg::ID_NUMBER, scc_pkg::ID_TYPE, 8'h01}, "id");
      end
      bus(0, 0, 9'h0F0, 32'h0, 1);
      check(rd, 32'h0000_0000, "unmapped read");
      // every mode code, disabled first as software must
      for (int m = 0; m < 16; m++) begin
         bus(1, 0, scc_pkg::OFS_CCR, 32'h0, 1);
         bus(1, 0, scc_pkg::OFS_CCR, m, 1);
         check(MODE_O, (m > 4) ? 8'h00 : 8'(m), "mode");
      end
      bus(1, 1, scc_pkg::OFS_CCR, 32'h2, 1);
      check(MODE_O, 8'h20, "second window mode");
      bus(1, 1, scc_pkg::OFS_CCR, 32'h0, 1);
      bus(1, 0, scc_pkg::OFS_CCR, 32'hFFFF_FFFF, 1);
      bus(0, 0, scc_pkg::OFS_CCR, 32'h0, 0);
      check(rd, 32'h0001_FFCF, "unused bits");
      // port lines and parity with an odd count of ones
      PAR_DATA_I <= 32'h0000_0007;
      for (int h = 0; h < 4; h++) begin
         bus(1, 0, scc_pkg::OFS_CCR, 32'h1 | (h << 6) | (h << 8), 1);
         check(PORT_IN_EN_O, hin[h], "port in");
         check(PORT_OUT_EN_O, hout[h], "port out");
         check(PAR_EN_O, h >> 1, "parity enable");
         check(PAR_BIT_O, h == 2, "parity bit");
      end
      PAR_DATA_I <= 32'h0000_0003;
      repeat (2) @(posedge REF_CLK);
      #1;
      check(PAR_BIT_O, 32'h1, "even count parity");
      // divider needs privilege; the violation is flagged in status
      bus(1, 0, scc_pkg::OFS_IRQ_CLR, 32'hF, 1);
      bus(1, 0, scc_pkg::OFS_FDR, 32'hA5A5_0001, 0);
      bus(0, 0, scc_pkg::OFS_FDR, 32'h0, 1);
      check(rd, 32'h0000_0000, "divider unprivileged");
      bus(1, 0, scc_pkg::OFS_FDR, 32'hA5A5_0001, 1);
      check(FDIV_O[31:0], 32'hA5A5_0001, "divider privileged");
      bus(0, 0, scc_pkg::OFS_IRQ_STAT, 32'h0, 0);
      check(rd, 32'h0000_0004, "violation status");
      // receiver start routing, masking and clearing
      bus(1, 0, scc_pkg::OFS_IRQ_CLR, 32'hF, 1);
      bus(1, 0, scc_pkg::OFS_IRQ_EN, 32'h1, 1);
      bus(1, 0, scc_pkg::OFS_CCR, 32'h0000_0400, 1);
      TB_NODE_PTR_I <= 6'h15;
      pulse(2'h1, 6'h20);
      check(IRQ_O, 32'h1, "irq raised");
      pulse(2'h2, 6'h00);
      bus(0, 1, scc_pkg::OFS_IRQ_STAT, 32'h0, 0);
      check(rd, 32'h0000_0003, "event status");
      bus(1, 0, scc_pkg::OFS_IRQ_EN, 32'h0, 1);
      check(IRQ_O, 32'h0, "irq masked");
      bus(1, 0, scc_pkg::OFS_IRQ_EN, 32'h2, 1);
      check(IRQ_O, 32'h1, "irq enabled");
      bus(1, 0, scc_pkg::OFS_IRQ_CLR, 32'h3, 1);
      check(IRQ_O, 32'h0, "irq cleared");
      TB_NODE_PTR_I <= 6'h16;
      pulse(2'h1, 6'h00);
      TB_NODE_PTR_I <= 6'h15;
      bus(1, 0, scc_pkg::OFS_CCR, 32'h0, 1);
      pulse(2'h1, 6'h00);
      print_verdict();
   end
endmodule : scc_regs_test
